// File: src/pcm_top.sv
// Purpose: Program counter with instruction memory map and external fetch port.
// Assumes: One fetch per fetch_en cycle; external memory answers in one cycle.
// Notes: Wait states are outside this block.
`timescale 1ns/1ps
`include "pcm_params.svh"

// Function
// - 16-bit counter holds executing instruction address.
// - Counter loadable and readable over main bus.
// - Interrupt take loads vector, pushes return address.
// - Lowest 256 words decode to boot ROM.
// - 64-word vector area above reserved block.
// - 1.5K-word internal RAM above vectors.
// - Upper 48K words decode to external window.
// - External memory is never data space.
// - Counter increments by one per fetch.
// - External port: 16-bit address, 32-bit data.
module pcm_top
#(
  parameter int ADDR_W = `PCM_ADDR_W,
  parameter int DATA_W = `PCM_DATA_W
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fetch_en,
  input pcm_pkg::pcm_load_s bus_load,
  input pcm_pkg::pcm_irq_s irq_take,
  input wire logic [DATA_W-1:0] imem_data_lines,
  output logic [ADDR_W-1:0] instr_addr_counter,
  output logic [ADDR_W-1:0] return_addr,
  output logic return_push,
  output logic [ADDR_W-1:0] imem_addr_lines,
  output logic imem_rd_n,
  output logic [DATA_W-1:0] instr_word,
  output logic instr_valid,
  output pcm_pkg::pcm_sel_s region_sel,
  output logic undefined_fetch
);
  import pcm_pkg::*;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // The carrier structs fix the address width and the data width must match PCM_DATA_W, so other sizes are refused here.
  if (ADDR_W != `PCM_ADDR_W)
  begin
    $error("pcm_top: ADDR_W must equal the carrier address width");
  end
  if (DATA_W != `PCM_DATA_W)
  begin
    $error("pcm_top: DATA_W must equal the carrier data width");
  end

  // The decode is a priority chain, so the regions must not overlap.
  if (`PCM_BOOT_HI >= `PCM_SYS0_LO)
  begin
    $error("pcm_top: boot and first reserved regions overlap");
  end
  if (`PCM_SYS0_HI >= `PCM_VEC_LO)
  begin
    $error("pcm_top: first reserved and vector regions overlap");
  end
  if (`PCM_VEC_HI >= `PCM_IRAM_LO)
  begin
    $error("pcm_top: vector and internal RAM regions overlap");
  end
  if (`PCM_IRAM_HI >= `PCM_SYS1_LO)
  begin
    $error("pcm_top: internal RAM and second reserved regions overlap");
  end
  if (`PCM_SYS1_HI >= `PCM_EXT_LO)
  begin
    $error("pcm_top: second reserved and external regions overlap");
  end

  // A region whose bounds are swapped would never decode.
  if (`PCM_BOOT_LO > `PCM_BOOT_HI)
  begin
    $error("pcm_top: boot region bounds swapped");
  end
  if (`PCM_SYS0_LO > `PCM_SYS0_HI)
  begin
    $error("pcm_top: first reserved region bounds swapped");
  end
  if (`PCM_VEC_LO > `PCM_VEC_HI)
  begin
    $error("pcm_top: vector region bounds swapped");
  end
  if (`PCM_IRAM_LO > `PCM_IRAM_HI)
  begin
    $error("pcm_top: internal RAM region bounds swapped");
  end
  if (`PCM_SYS1_LO > `PCM_SYS1_HI)
  begin
    $error("pcm_top: second reserved region bounds swapped");
  end
  if (`PCM_EXT_LO > `PCM_EXT_HI)
  begin
    $error("pcm_top: external region bounds swapped");
  end

  // The external window must run to the top of the space.
  if (`PCM_EXT_HI != {ADDR_W{1'h1}})
  begin
    $error("pcm_top: external window must end at the last address");
  end

  // Execution after reset has to start inside the boot ROM.
  if (`PCM_PC_RESET > `PCM_BOOT_HI)
  begin
    $error("pcm_top: reset address lies outside the boot ROM");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] pc;
    logic [ADDR_W-1:0] ret;
    logic push;
    logic [ADDR_W-1:0] ia;
    logic rd_n;
    logic ext_pend;
    logic [DATA_W-1:0] word;
    logic valid;
    pcm_sel_s sel;
    logic undef;
  } pcm_state_s;

  pcm_state_s st;
  pcm_state_s next_st;
  pcm_sel_s dec_sel;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // The step is cut to the counter width, so the counter wraps at the top.
  function automatic logic [ADDR_W-1:0] pcm_step(input logic [ADDR_W-1:0] a);
    pcm_step = a + ADDR_W'(`PCM_PC_STEP);
  endfunction

  // The read strobe idles high, so reset cannot simply clear every bit.
  function automatic pcm_state_s pcm_reset_state();
    pcm_state_s s;
    s = '0;
    s.pc = `PCM_PC_RESET;
    s.rd_n = 1'h1;
    return s;
  endfunction

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  pcm_decode u_decode (
    .addr(st.pc),
    .sel(dec_sel),
    .region()
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // The interrupt wins over a bus load so that an accepted interrupt is never lost.
  always_comb
  begin
    next_st = st;
    next_st.push = 1'h0;
    next_st.valid = 1'h0;
    next_st.rd_n = 1'h1;
    next_st.ext_pend = 1'h0;
    next_st.undef = 1'h0;
    next_st.sel = dec_sel;
    if (irq_take.take)
    begin
      next_st.ret = st.pc;
      next_st.push = 1'h1;
      next_st.pc = irq_take.vector;
    end
    else if (bus_load.load)
    begin
      next_st.pc = bus_load.data;
    end
    else if (fetch_en)
    begin
      next_st.pc = pcm_step(st.pc);
      // A fetch refused by a load or an interrupt is not flagged.
      next_st.undef = dec_sel.reserved_hit;
      if (dec_sel.ext_sel)
      begin
        next_st.ia = st.pc;
        next_st.rd_n = 1'h0;
        next_st.ext_pend = 1'h1;
      end
    end
    // Only fetches reach the external port; no data path drives it.
    if (st.ext_pend)
    begin
      next_st.word = imem_data_lines;
      next_st.valid = 1'h1;
    end
  end

  // ----------------------------------------
  // Register
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st <= pcm_reset_state();
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign instr_addr_counter = st.pc;
  assign return_addr = st.ret;
  assign return_push = st.push;
  assign imem_addr_lines = st.ia;
  assign imem_rd_n = st.rd_n;
  assign instr_word = st.word;
  assign instr_valid = st.valid;
  assign region_sel = st.sel;
  assign undefined_fetch = st.undef;

endmodule

// File: src/pcm_params.svh
// Purpose: Constants for the program counter and instruction memory map.
// Assumes: 16-bit instruction address space, 32-bit instruction words.
// Notes: Region bounds are inclusive first and last word addresses.
`ifndef PCM_PARAMS_SVH
`define PCM_PARAMS_SVH

`define PCM_ADDR_W 16
`define PCM_DATA_W 32
`define PCM_PC_RESET 16'h0000
`define PCM_PC_STEP 16'h0001
`define PCM_BOOT_LO 16'h0000
`define PCM_BOOT_HI 16'h00FF
`define PCM_SYS0_LO 16'h0100
`define PCM_SYS0_HI 16'h01FF
`define PCM_VEC_LO 16'h0200
`define PCM_VEC_HI 16'h023F
`define PCM_IRAM_LO 16'h0240
`define PCM_IRAM_HI 16'h083F
`define PCM_SYS1_LO 16'h0840
`define PCM_SYS1_HI 16'h3FFF
`define PCM_EXT_LO 16'h4000
`define PCM_EXT_HI 16'hFFFF

`endif

// File: src/pcm_pkg.sv
// Purpose: Types for the program counter and instruction memory map.
// Assumes: Constants come from pcm_params.svh.
// Notes: Region codes are an enum without fixed encodings.
`include "pcm_params.svh"
package pcm_pkg;
  typedef enum logic [2:0] {
    PCM_REG_BOOT,
    PCM_REG_SYS,
    PCM_REG_VEC,
    PCM_REG_IRAM,
    PCM_REG_EXT
  } pcm_region_e;

  typedef struct packed {
    logic boot_sel;
    logic vec_sel;
    logic iram_sel;
    logic ext_sel;
    logic reserved_hit;
  } pcm_sel_s;

  typedef struct packed {
    logic load;
    logic [`PCM_ADDR_W-1:0] data;
  } pcm_load_s;

  typedef struct packed {
    logic take;
    logic [`PCM_ADDR_W-1:0] vector;
  } pcm_irq_s;
endpackage

// File: src/pcm_decode.sv
// Purpose: Decodes an instruction address into its memory region.
// Assumes: Purely combinational, fed from a registered address.
// Notes: Reserved regions raise reserved_hit and select nothing.
`timescale 1ns/1ps
`include "pcm_params.svh"
module pcm_decode
(
  input wire logic [`PCM_ADDR_W-1:0] addr,
  output pcm_pkg::pcm_sel_s sel,
  output pcm_pkg::pcm_region_e region
);
  import pcm_pkg::*;

  function automatic logic pcm_in(input logic [`PCM_ADDR_W-1:0] a,
                                  input logic [`PCM_ADDR_W-1:0] lo,
                                  input logic [`PCM_ADDR_W-1:0] hi);
    pcm_in = (a >= lo) && (a <= hi);
  endfunction

  always_comb
  begin
    sel = '0;
    region = PCM_REG_SYS;
    if (pcm_in(addr, `PCM_BOOT_LO, `PCM_BOOT_HI))
    begin
      sel.boot_sel = 1'h1;
      region = PCM_REG_BOOT;
    end
    else if (pcm_in(addr, `PCM_VEC_LO, `PCM_VEC_HI))
    begin
      sel.vec_sel = 1'h1;
      region = PCM_REG_VEC;
    end
    else if (pcm_in(addr, `PCM_IRAM_LO, `PCM_IRAM_HI))
    begin
      sel.iram_sel = 1'h1;
      region = PCM_REG_IRAM;
    end
    else if (pcm_in(addr, `PCM_EXT_LO, `PCM_EXT_HI))
    begin
      sel.ext_sel = 1'h1;
      region = PCM_REG_EXT;
    end
    else
    begin
      sel.reserved_hit = 1'h1;
    end
  end

endmodule

// File: dv/pcm_top_sva.sv
// Purpose: Checks counter, decode and fetch port timing of pcm_top.
// Assumes: Region bounds as in pcm_params.svh.
// Notes: pc_q is the counter one cycle back, so region checks see one-late decode.
`timescale 1ns/1ps
module pcm_top_sva
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fetch_en,
  input pcm_pkg::pcm_load_s bus_load,
  input pcm_pkg::pcm_irq_s irq_take,
  input wire logic [31:0] imem_data_lines,
  input wire logic [15:0] instr_addr_counter,
  input wire logic [15:0] return_addr,
  input wire logic return_push,
  input wire logic [15:0] imem_addr_lines,
  input wire logic imem_rd_n,
  input wire logic [31:0] instr_word,
  input wire logic instr_valid,
  input pcm_pkg::pcm_sel_s region_sel,
  input wire logic undefined_fetch
);
  import pcm_pkg::*;
  logic [15:0] pc_q;
  logic sf;
  assign sf = fetch_en & !bus_load.load & !irq_take.take;
  always_ff @(posedge clk) pc_q <= instr_addr_counter;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_bus_load: assert property (bus_load.load && !irq_take.take |=>
    instr_addr_counter == $past(bus_load.data)) else $error("load");
  chk_irq_take: assert property (irq_take.take |=>
    instr_addr_counter == $past(irq_take.vector) && return_push) else $error("irq");
  chk_seq_inc: assert property (sf |=> instr_addr_counter == pc_q + 16'h0001)
    else $error("inc");
  chk_ext_strobe: assert property (sf && instr_addr_counter >= 16'h4000 |=>
    !imem_rd_n && imem_addr_lines == pc_q) else $error("strobe");
  chk_no_stray: assert property (!imem_rd_n |-> pc_q >= 16'h4000 && $past(sf))
    else $error("stray");
  chk_word_cap: assert property (!imem_rd_n |=>
    instr_valid && instr_word == $past(imem_data_lines)) else $error("word");
  chk_undef_flag: assert property (sf && instr_addr_counter inside
    {[16'h0100:16'h01FF], [16'h0840:16'h3FFF]} |=> undefined_fetch) else $error("undef");
  chk_boot_sel: assert property (1'b1 |=> region_sel.boot_sel == (pc_q <= 16'h00FF))
    else $error("boot");
  chk_vec_sel: assert property (1'b1 |=>
    region_sel.vec_sel == (pc_q inside {[16'h0200:16'h023F]})) else $error("vec");
  chk_iram_sel: assert property (1'b1 |=>
    region_sel.iram_sel == (pc_q inside {[16'h0240:16'h083F]})) else $error("iram");
  chk_ext_sel: assert property (1'b1 |=>
    region_sel.ext_sel == (pc_q >= 16'h4000)) else $error("ext");
  chk_rsv_sel: assert property (1'b1 |=> region_sel.reserved_hit ==
    (pc_q inside {[16'h0100:16'h01FF], [16'h0840:16'h3FFF]})) else $error("rsv");
  chk_undef_src: assert property (undefined_fetch |->
    $past(sf) && region_sel.reserved_hit) else $error("undef source");
  chk_ret_addr: assert property (irq_take.take |=>
    return_addr == $past(instr_addr_counter)) else $error("ret");
endmodule
bind pcm_top pcm_top_sva u_sva (.*);

// File: dv/pcm_imem_model.sv
// Purpose: External instruction memory answering each read strobe at once.
// Assumes: The word at an address is the inverted address above the address.
// Notes: Released lines show the inverse of the last word, so stale data cannot pass.
`timescale 1ns/1ps
module pcm_imem_model
(
  input wire logic clk,
  input wire logic [15:0] addr,
  input wire logic rd_n,
  output logic [31:0] data
);
  logic [31:0] last = 32'h0;
  always @(posedge clk) last <= data;
  assign data = rd_n ? ~last : {~addr, addr};
endmodule

// File: dv/pcm_top_tb.sv
// Purpose: Drives loads, interrupts and fetches through pcm_top.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: Checks sit 1 ns after the edge, once updates have landed.
`timescale 1ns/1ps
module pcm_top_tb;
  import pcm_pkg::*;
  logic clk = 0, rst_n = 0, fetch_en = 0, return_push, imem_rd_n, instr_valid, undefined_fetch;
  pcm_load_s bus_load = '0;
  pcm_irq_s irq_take = '0;
  pcm_sel_s region_sel;
  logic [31:0] imem_data_lines, instr_word;
  logic [15:0] instr_addr_counter, return_addr, imem_addr_lines;
  int n_fail = 0, cmp_count = 0, cyc = 0;
  pcm_top dut (.clk(clk), .rst_n(rst_n), .fetch_en(fetch_en), .bus_load(bus_load),
    .irq_take(irq_take), .imem_data_lines(imem_data_lines),
    .instr_addr_counter(instr_addr_counter), .return_addr(return_addr),
    .return_push(return_push), .imem_addr_lines(imem_addr_lines), .imem_rd_n(imem_rd_n),
    .instr_word(instr_word), .instr_valid(instr_valid), .region_sel(region_sel),
    .undefined_fetch(undefined_fetch));
  pcm_imem_model mem (.clk(clk), .addr(imem_addr_lines), .rd_n(imem_rd_n),
    .data(imem_data_lines));
  initial forever #12.5 clk = ~clk;
  task give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Ceiling: the run needs well under 100 cycles.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_fail++;
      give_verdict;
    end
  end
  task ck(string n, logic [31:0] e, logic [31:0] s);
    cmp_count++;
    if (s !== e)
    begin
      $display("BAD %s exp %h got %h", n, e, s);
      n_fail++;
    end
  endtask
  task drv(logic l, logic [15:0] d, logic t, logic [15:0] v, logic f);
    bus_load = '{l, d};
    irq_take = '{t, v};
    fetch_en = f;
    @(posedge clk);
    #1;
  endtask
  task s_ext;
    drv(1, 16'h3FFF, 0, 0, 0);
    drv(0, 0, 0, 0, 1);
    ck("undef", 1, undefined_fetch);
    ck("rsv", 1, region_sel.reserved_hit);
    ck("rd_n", 1, imem_rd_n);
    drv(0, 0, 0, 0, 1);
    ck("pc", 16'h4001, instr_addr_counter);
    ck("ext", 1, region_sel.ext_sel);
    ck("rd_n_lo", 0, imem_rd_n);
    ck("ia", 16'h4000, imem_addr_lines);
    drv(0, 0, 0, 0, 0);
    ck("word", 32'hBFFF4000, instr_word);
    ck("valid", 1, instr_valid);
    ck("rd_n", 1, imem_rd_n);
  endtask
  task s_irq;
    drv(1, 16'h4000, 1, 16'h0210, 1);
    ck("pc", 16'h0210, instr_addr_counter);
    ck("push", 1, return_push);
    ck("ret", 16'h4001, return_addr);
    ck("rd_n", 1, imem_rd_n);
    drv(0, 0, 0, 0, 0);
    ck("vec", 1, region_sel.vec_sel);
    ck("push_end", 0, return_push);
  endtask
  task s_iram;
    drv(1, 16'h083F, 0, 0, 1);
    drv(0, 0, 0, 0, 1);
    ck("iram", 1, region_sel.iram_sel);
    ck("rd_n", 1, imem_rd_n);
    ck("undef0", 0, undefined_fetch);
    drv(0, 0, 0, 0, 1);
    ck("undef", 1, undefined_fetch);
    ck("rsv", 1, region_sel.reserved_hit);
    ck("pc", 16'h0841, instr_addr_counter);
  endtask
  task s_rst;
    rst_n = 0;
    drv(0, 0, 1, 16'h4000, 1);
    ck("pc_rst", 0, instr_addr_counter);
    ck("push_rst", 0, return_push);
    ck("ret_rst", 0, return_addr);
    ck("rd_n_rst", 1, imem_rd_n);
    rst_n = 1;
    drv(1, 16'h4000, 0, 0, 0);
    ck("boot_rst", 1, region_sel.boot_sel);
    ck("pc_ld", 16'h4000, instr_addr_counter);
    drv(0, 0, 0, 0, 1);
    ck("ia0", 16'h4000, imem_addr_lines);
    drv(0, 0, 0, 0, 1);
    ck("ia1", 16'h4001, imem_addr_lines);
    ck("word0", 32'hBFFF4000, instr_word);
    drv(0, 0, 0, 0, 0);
    ck("word1", 32'hBFFE4001, instr_word);
    ck("valid1", 1, instr_valid);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    #1;
    ck("pc0", 0, instr_addr_counter);
    rst_n = 1;
    drv(0, 0, 0, 0, 0);
    ck("boot", 1, region_sel.boot_sel);
    s_ext();
    s_irq();
    s_iram();
    s_rst();
    give_verdict;
  end
endmodule
